// *** core/fth_regs.sv ***
// register bank: parity span, level thresholds, header capture, axi4-lite slave
`timescale 1ns/1ps

// Functional notes
// - parity covers mode-switch bits 0..10 when range select is 0, 0..14 when 1.
// - during cca the channel is busy when level is at or above busy threshold.
// - thresholds are 10-bit two's complement, bit 9 sign, compared at 10 bits.
// - receive level filter passes only levels strictly above its threshold.
// - non mode-switch fsk frames load header bits 0..4 into capture register.
// - capture reads return the copy of the bank picked by bank select.
// - parity error flag is 1 on failed check over span, else 0.
module fth_regs
  import fth_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              arst_n,
  input  wire logic              ce,
  input  wire logic [AXI_AW-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [AXI_DW-1:0] s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [AXI_AW-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [AXI_DW-1:0]      s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  input  wire logic              ms_frame_valid,
  input  wire logic [MS_W-1:0]   ms_frame_bits,
  input  wire logic              cca_active,
  input  wire logic [LVL_W-1:0]  rx_level,
  input  wire logic              hdr_store,
  input  wire logic              hdr_is_ms,
  input  wire logic              hdr_bank,
  input  wire logic [HDR_W-1:0]  hdr_bits,
  output logic                   parity_error_flag,
  output logic                   channel_busy,
  output logic                   level_pass
);

  logic              aw_hold;
  logic [IDX_W-1:0]  aw_idx;
  logic              w_hold;
  logic [AXI_DW-1:0] w_data;
  logic [3:0]        w_strb;
  logic              parity_range_select;
  logic [LVL_W-1:0]  busy_threshold_value;
  logic [LVL_W-1:0]  filter_threshold_value;
  logic              bank_select;
  logic [HDR_W-1:0]  hdr_copy [2];

  logic              next_aw_hold;
  logic [IDX_W-1:0]  next_aw_idx;
  logic              next_w_hold;
  logic [AXI_DW-1:0] next_w_data;
  logic [3:0]        next_w_strb;
  logic              next_awready;
  logic              next_wready;
  logic              next_bvalid;
  logic [1:0]        next_bresp;
  logic              next_arready;
  logic              next_rvalid;
  logic [AXI_DW-1:0] next_rdata;
  logic [1:0]        next_rresp;
  logic              next_range_select;
  logic [LVL_W-1:0]  next_busy_thr;
  logic [LVL_W-1:0]  next_filt_thr;
  logic              next_bank_select;
  logic [HDR_W-1:0]  next_hdr_copy [2];
  logic              next_pe;
  logic              next_busy;
  logic              next_pass;
  logic              do_write;
  logic [IDX_W-1:0]  ar_idx;

  assign do_write = aw_hold && w_hold && !s_axi_bvalid;
  assign ar_idx   = s_axi_araddr[IDX_LSB +: IDX_W];

  function automatic logic lane_ok(input logic [IDX_W-1:0] idx);
    lane_ok = (idx == IDX_MS_STATUS) || (idx == IDX_MS_CTRL) || (idx == IDX_BUSY_THR)
           || (idx == IDX_FILT_THR) || (idx == IDX_HDR) || (idx == IDX_BANK_SEL)
           || (idx == IDX_LVL_STAT);
  endfunction

  // read mux, all unlisted bits read zero
  always_comb begin
    next_rdata = s_axi_rdata;
    next_rresp = s_axi_rresp;
    if (s_axi_arvalid && s_axi_arready) begin
      next_rdata = WORD_ZERO;
      next_rresp = lane_ok(ar_idx) ? RESP_OKAY : RESP_SLVERR;
      unique case (ar_idx)
        IDX_MS_STATUS: next_rdata[PE_BIT] = parity_error_flag;
        IDX_MS_CTRL:   next_rdata[RANGE_SEL_BIT] = parity_range_select;
        IDX_BUSY_THR:  next_rdata[LVL_W-1:0] = busy_threshold_value;
        IDX_FILT_THR:  next_rdata[LVL_W-1:0] = filter_threshold_value;
        IDX_HDR:       next_rdata[HDR_W-1:0] = hdr_copy[bank_select];
        IDX_BANK_SEL:  next_rdata[BANK_SEL_BIT] = bank_select;
        IDX_LVL_STAT: begin
          next_rdata[BUSY_BIT] = channel_busy;
          next_rdata[PASS_BIT] = level_pass;
        end
        default:       next_rdata = WORD_ZERO;
      endcase
    end
  end

  // axi handshakes
  always_comb begin
    next_aw_hold = aw_hold;
    next_aw_idx  = aw_idx;
    next_w_hold  = w_hold;
    next_w_data  = w_data;
    next_w_strb  = w_strb;
    next_bvalid  = s_axi_bvalid;
    next_bresp   = s_axi_bresp;
    next_rvalid  = s_axi_rvalid;
    if (s_axi_awvalid && s_axi_awready) begin
      next_aw_hold = 1'b1;
      next_aw_idx  = s_axi_awaddr[IDX_LSB +: IDX_W];
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_w_hold = 1'b1;
      next_w_data = s_axi_wdata;
      next_w_strb = s_axi_wstrb;
    end
    if (s_axi_bvalid && s_axi_bready) begin
      next_bvalid = 1'b0;
    end
    if (do_write) begin
      next_aw_hold = 1'b0;
      next_w_hold  = 1'b0;
      next_bvalid  = 1'b1;
      next_bresp   = lane_ok(aw_idx) ? RESP_OKAY : RESP_SLVERR;
    end
    if (s_axi_rvalid && s_axi_rready) begin
      next_rvalid = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      next_rvalid = 1'b1;
    end
    next_awready = !next_aw_hold && !next_bvalid;
    next_wready  = !next_w_hold && !next_bvalid;
    next_arready = !next_rvalid;
  end

  // register writes, only implemented bits are kept
  always_comb begin
    next_range_select = parity_range_select;
    next_busy_thr     = busy_threshold_value;
    next_filt_thr     = filter_threshold_value;
    next_bank_select  = bank_select;
    if (do_write && w_strb[0]) begin
      unique case (aw_idx)
        IDX_MS_CTRL:  next_range_select = w_data[RANGE_SEL_BIT];
        IDX_BUSY_THR: next_busy_thr[LANE0_HI:0] = w_data[LANE0_HI:0];
        IDX_FILT_THR: next_filt_thr[LANE0_HI:0] = w_data[LANE0_HI:0];
        IDX_BANK_SEL: next_bank_select = w_data[BANK_SEL_BIT];
        default:      next_bank_select = bank_select;
      endcase
    end
    if (do_write && w_strb[1]) begin
      if (aw_idx == IDX_BUSY_THR) begin
        next_busy_thr[LVL_W-1:LANE1_LO] = w_data[LVL_W-1:LANE1_LO];
      end
      if (aw_idx == IDX_FILT_THR) begin
        next_filt_thr[LVL_W-1:LANE1_LO] = w_data[LVL_W-1:LANE1_LO];
      end
    end
  end

  // receive side status and capture
  always_comb begin
    next_pe          = parity_error_flag;
    next_hdr_copy[0] = hdr_copy[0];
    next_hdr_copy[1] = hdr_copy[1];
    if (ms_frame_valid) begin
      next_pe = ^(ms_frame_bits & (parity_range_select ? SPAN_LONG : SPAN_SHORT));
    end
    // signed codes in half-dBm steps
    next_busy = cca_active && ($signed(rx_level) >= $signed(busy_threshold_value));
    next_pass = $signed(rx_level) > $signed(filter_threshold_value);
    if (hdr_store && !hdr_is_ms) begin
      next_hdr_copy[hdr_bank] = hdr_bits;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      aw_hold                <= 1'b0;
      aw_idx                 <= '0;
      w_hold                 <= 1'b0;
      w_data                 <= WORD_ZERO;
      w_strb                 <= 4'h0;
      s_axi_awready          <= 1'b0;
      s_axi_wready           <= 1'b0;
      s_axi_bvalid           <= 1'b0;
      s_axi_bresp            <= RESP_OKAY;
      s_axi_arready          <= 1'b0;
      s_axi_rvalid           <= 1'b0;
      s_axi_rdata            <= WORD_ZERO;
      s_axi_rresp            <= RESP_OKAY;
      parity_range_select    <= MS_CTRL_RST;
      busy_threshold_value   <= THR_RST;
      filter_threshold_value <= THR_RST;
      bank_select            <= BANK_SEL_RST;
      hdr_copy[0]            <= HDR_RST;
      hdr_copy[1]            <= HDR_RST;
      parity_error_flag      <= 1'b0;
      channel_busy           <= 1'b0;
      level_pass             <= 1'b0;
    end else if (ce) begin
      aw_hold                <= next_aw_hold;
      aw_idx                 <= next_aw_idx;
      w_hold                 <= next_w_hold;
      w_data                 <= next_w_data;
      w_strb                 <= next_w_strb;
      s_axi_awready          <= next_awready;
      s_axi_wready           <= next_wready;
      s_axi_bvalid           <= next_bvalid;
      s_axi_bresp            <= next_bresp;
      s_axi_arready          <= next_arready;
      s_axi_rvalid           <= next_rvalid;
      s_axi_rdata            <= next_rdata;
      s_axi_rresp            <= next_rresp;
      parity_range_select    <= next_range_select;
      busy_threshold_value   <= next_busy_thr;
      filter_threshold_value <= next_filt_thr;
      bank_select            <= next_bank_select;
      hdr_copy[0]            <= next_hdr_copy[0];
      hdr_copy[1]            <= next_hdr_copy[1];
      parity_error_flag      <= next_pe;
      channel_busy           <= next_busy;
      level_pass             <= next_pass;
    end
  end

  // checks
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!arst_n);

  sequence s_ms_long;
    ce && ms_frame_valid && parity_range_select;
  endsequence

  sequence s_ms_short;
    ce && ms_frame_valid && !parity_range_select;
  endsequence

  a_parity_long_span: assert property (
    s_ms_long |=> parity_error_flag == ^($past(ms_frame_bits) & SPAN_LONG))
    else $error("parity over bits 0..14 wrong");

  a_parity_short_span: assert property (
    s_ms_short |=> parity_error_flag == ^($past(ms_frame_bits[10:0])))
    else $error("parity over bits 0..10 wrong");

  a_busy_compare: assert property (
    ce && cca_active && ($signed(rx_level) >= $signed(busy_threshold_value))
    |=> channel_busy)
    else $error("channel not busy at or above threshold");

  a_busy_below: assert property (
    ce && ($signed(rx_level) < $signed(busy_threshold_value)) |=> !channel_busy)
    else $error("channel busy below threshold");

  a_filter_strict: assert property (
    ce |=> level_pass == ($signed($past(rx_level)) > $signed($past(filter_threshold_value))))
    else $error("level filter not strictly above threshold");

  a_hdr_capture: assert property (
    ce && hdr_store && !hdr_is_ms |=> hdr_copy[$past(hdr_bank)] == $past(hdr_bits))
    else $error("header bits not captured");

  a_hdr_ms_hold: assert property (
    ce && !(hdr_store && !hdr_is_ms) |=> $stable(hdr_copy[0]) && $stable(hdr_copy[1]))
    else $error("header capture changed without store");

  a_hdr_read_bank: assert property (
    ce && s_axi_arvalid && s_axi_arready && ar_idx == IDX_HDR
    |=> s_axi_rvalid && s_axi_rdata == {27'h0, $past(hdr_copy[bank_select])})
    else $error("header read from wrong bank");

  a_thr_upper_zero: assert property (
    ce && s_axi_arvalid && s_axi_arready && (ar_idx == IDX_BUSY_THR || ar_idx == IDX_FILT_THR)
    |=> s_axi_rdata[AXI_DW-1:LVL_W] == '0)
    else $error("threshold upper bits not zero");

  a_write_resp_time: assert property (
    ce && aw_hold && w_hold && !s_axi_bvalid |=> s_axi_bvalid ##1 !(aw_hold || w_hold) [*1])
    else $error("write response late");

endmodule

// *** core/fth_pkg.sv ***
// constants for the fsk threshold and header capture register bank
package fth_pkg;
  // bus geometry
  localparam int          AXI_AW        = 12;
  localparam int          AXI_DW        = 32;
  localparam int          IDX_W         = 10;
  localparam int          IDX_LSB       = 2;
  // register indices, byte address is four times the index
  localparam logic [9:0]  IDX_MS_STATUS = 10'h168;
  localparam logic [9:0]  IDX_MS_CTRL   = 10'h169;
  localparam logic [9:0]  IDX_BUSY_THR  = 10'h16A;
  localparam logic [9:0]  IDX_FILT_THR  = 10'h16C;
  localparam logic [9:0]  IDX_HDR       = 10'h16E;
  localparam logic [9:0]  IDX_BANK_SEL  = 10'h180;
  localparam logic [9:0]  IDX_LVL_STAT  = 10'h181;
  // field layout
  localparam int          LVL_W         = 10;
  localparam int          HDR_W         = 5;
  localparam int          MS_W          = 16;
  localparam int          RANGE_SEL_BIT = 0;
  localparam int          PE_BIT        = 1;
  localparam int          BANK_SEL_BIT  = 0;
  localparam int          BUSY_BIT      = 0;
  localparam int          PASS_BIT      = 1;
  localparam int          LANE0_HI      = 7;
  localparam int          LANE1_LO      = 8;
  localparam int          HDR_DW_BIT    = 4;
  localparam int          HDR_FCS_BIT   = 3;
  localparam int          HDR_MS_BIT    = 0;
  // parity spans: bits 0..10 and bits 0..14
  localparam logic [15:0] SPAN_SHORT    = 16'h07FF;
  localparam logic [15:0] SPAN_LONG     = 16'h7FFF;
  // reset values
  localparam logic        MS_CTRL_RST   = 1'h0;
  localparam logic [9:0]  THR_RST       = 10'h200;
  localparam logic [4:0]  HDR_RST       = 5'h00;
  localparam logic        BANK_SEL_RST  = 1'h0;
  // responses
  localparam logic [1:0]  RESP_OKAY     = 2'h0;
  localparam logic [1:0]  RESP_SLVERR   = 2'h2;
  localparam logic [31:0] WORD_ZERO     = 32'h00000000;
endpackage

// *** testbench/fth_host_model.sv ***
// host model: axi4-lite master for register reads and writes
`timescale 1ns/1ps
module fth_host_model (
  input  wire logic        clk,
  output logic [11:0]      s_axi_awaddr,
  output logic             s_axi_awvalid,
  input  wire logic        s_axi_awready,
  output logic [31:0]      s_axi_wdata,
  output logic             s_axi_wvalid,
  input  wire logic        s_axi_wready,
  input  wire logic [1:0]  s_axi_bresp,
  input  wire logic        s_axi_bvalid,
  output logic             s_axi_bready,
  output logic [11:0]      s_axi_araddr,
  output logic             s_axi_arvalid,
  input  wire logic        s_axi_arready,
  input  wire logic [31:0] s_axi_rdata,
  input  wire logic [1:0]  s_axi_rresp,
  input  wire logic        s_axi_rvalid,
  output logic             s_axi_rready
);
  initial begin
    {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
  end
  // address and data offered together, each released when taken
  task automatic wr(input logic [9:0] idx, input logic [31:0] d, output logic [1:0] r);
    logic a;
    logic w;
    a = 1'b0;
    w = 1'b0;
    @(posedge clk);
    s_axi_awaddr <= {idx, 2'h0};
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(a && w)) begin
      @(posedge clk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      a = a | s_axi_awready;
      w = w | s_axi_wready;
    end
    do @(posedge clk); while (!s_axi_bvalid);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input logic [9:0] idx, output logic [31:0] d, output logic [1:0] r);
    @(posedge clk);
    s_axi_araddr <= {idx, 2'h0};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge clk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge clk); while (!s_axi_rvalid);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
endmodule

// *** testbench/fsk_rx_threshold_phr_regs_tb_top.sv ***
// self-checking bench for the fsk threshold and header capture registers
`timescale 1ns/1ps
module fsk_rx_threshold_phr_regs_tb_top;
  import fth_pkg::*;
  typedef struct packed {
    logic [9:0] thr;
    logic [9:0] lvl;
    logic       cca;
    logic       busy;
    logic       pass;
  } fth_row_s;
  logic             clk, arst_n, ce, pe;
  logic [11:0]      s_axi_awaddr, s_axi_araddr;
  logic             s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic             s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic             s_axi_rvalid, s_axi_rready;
  logic [31:0]      s_axi_wdata, s_axi_rdata, rd_data;
  logic [3:0]       s_axi_wstrb;
  logic [1:0]       s_axi_bresp, s_axi_rresp, resp;
  logic             ms_frame_valid, cca_active, hdr_store, hdr_is_ms, hdr_bank;
  logic [MS_W-1:0]  ms_frame_bits;
  logic [LVL_W-1:0] rx_level;
  logic [HDR_W-1:0] hdr_bits;
  logic             parity_error_flag, channel_busy, level_pass;
  logic [15:0]      frames [4];
  fth_row_s         rows [7];
  int               errors, n_compared, cycles;

  fth_regs i_fth_regs (
    .clk, .arst_n, .ce, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .ms_frame_valid, .ms_frame_bits, .cca_active, .rx_level, .hdr_store,
    .hdr_is_ms, .hdr_bank, .hdr_bits, .parity_error_flag, .channel_busy, .level_pass
  );
  fth_host_model i_fth_host_model (
    .clk, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready
  );

  initial clk = 1'b0;
  always #5 clk = ~clk;
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      errors = errors + 1;
      summarize();
    end
  end

  task automatic summarize();
    $display("errors %0d compared %0d", errors, n_compared);
    if (errors == 0 && n_compared > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic rdchk(input logic [9:0] idx, input logic [31:0] exp, input logic [1:0] er);
    i_fth_host_model.rd(idx, rd_data, resp);
    chk(rd_data, exp);
    chk({30'h0, resp}, {30'h0, er});
  endtask
  task automatic wrchk(input logic [9:0] idx, input logic [31:0] d, input logic [1:0] er);
    i_fth_host_model.wr(idx, d, resp);
    chk({30'h0, resp}, {30'h0, er});
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic ms_frame(input logic [15:0] b);
    @(posedge clk);
    ms_frame_valid <= 1'b1;
    ms_frame_bits <= b;
    @(posedge clk);
    ms_frame_valid <= 1'b0;
    ms_frame_bits <= ~b;
    tick(1);
  endtask
  task automatic store(input logic ms, input logic bank, input logic [4:0] b);
    @(posedge clk);
    hdr_store <= 1'b1;
    hdr_is_ms <= ms;
    hdr_bank <= bank;
    hdr_bits <= b;
    @(posedge clk);
    hdr_store <= 1'b0;
    hdr_bits <= ~b;
  endtask

  initial begin
    rows = '{'{10'h33D, 10'h33D, 1'b1, 1'b1, 1'b0}, '{10'h33D, 10'h33C, 1'b1, 1'b0, 1'b0},
             '{10'h33D, 10'h33E, 1'b1, 1'b1, 1'b1}, '{10'h33D, 10'h33E, 1'b0, 1'b0, 1'b1},
             '{10'h000, 10'h3FF, 1'b1, 1'b0, 1'b0}, '{10'h3FF, 10'h000, 1'b1, 1'b1, 1'b1},
             '{10'h200, 10'h200, 1'b1, 1'b1, 1'b0}};
    frames = '{16'h0800, 16'h4000, 16'h8001, 16'h0401};
    {arst_n, pe, ms_frame_valid, cca_active, hdr_store, hdr_is_ms, hdr_bank} = '0;
    {ms_frame_bits, rx_level, hdr_bits} = '0;
    ce = 1'b1;
    s_axi_wstrb = 4'hF;
    errors = 0;
    n_compared = 0;
    cycles = 0;
    repeat (12) @(posedge clk);
    arst_n <= 1'b1;
    tick(2);
    foreach (rows[i]) begin
      wrchk(IDX_BUSY_THR, {22'h0, rows[i].thr}, RESP_OKAY);
      wrchk(IDX_FILT_THR, {22'h0, rows[i].thr}, RESP_OKAY);
      @(posedge clk);
      rx_level <= rows[i].lvl;
      cca_active <= rows[i].cca;
      tick(3);
      chk({31'h0, channel_busy}, {31'h0, rows[i].busy});
      chk({31'h0, level_pass}, {31'h0, rows[i].pass});
      rdchk(IDX_LVL_STAT, {30'h0, rows[i].pass, rows[i].busy}, RESP_OKAY);
      rdchk(IDX_BUSY_THR, {22'h0, rows[i].thr}, RESP_OKAY);
    end
    wrchk(IDX_FILT_THR, 32'h0000FD55, RESP_OKAY);
    rdchk(IDX_FILT_THR, 32'h00000155, RESP_OKAY);
    s_axi_wstrb <= 4'h1;
    wrchk(IDX_FILT_THR, 32'h000002AA, RESP_OKAY);
    s_axi_wstrb <= 4'hF;
    rdchk(IDX_FILT_THR, 32'h000001AA, RESP_OKAY);
    wrchk(IDX_BUSY_THR, 32'h00000000, RESP_OKAY);
    wrchk(IDX_FILT_THR, 32'h000003FF, RESP_OKAY);
    @(posedge clk);
    rx_level <= 10'h000;
    tick(3);
    chk({30'h0, level_pass, channel_busy}, 32'h00000003);
    wrchk(IDX_MS_CTRL, 32'h000000FF, RESP_OKAY);
    rdchk(IDX_MS_CTRL, 32'h00000001, RESP_OKAY);
    for (int s = 1; s >= 0; s--) begin
      wrchk(IDX_MS_CTRL, 32'(s), RESP_OKAY);
      foreach (frames[k]) begin
        ms_frame(frames[k]);
        pe = ^(frames[k] & ((s == 1) ? 16'h7FFF : 16'h07FF));
        chk({31'h0, parity_error_flag}, {31'h0, pe});
        rdchk(IDX_MS_STATUS, {30'h0, pe, 1'b0}, RESP_OKAY);
      end
    end
    store(1'b0, 1'b0, 5'h15);
    store(1'b0, 1'b1, 5'h0A);
    store(1'b1, 1'b0, 5'h1F);
    wrchk(IDX_HDR, 32'h0000001F, RESP_OKAY);
    wrchk(IDX_BANK_SEL, 32'h0, RESP_OKAY);
    rdchk(IDX_HDR, 32'h00000015, RESP_OKAY);
    wrchk(IDX_BANK_SEL, 32'h1, RESP_OKAY);
    rdchk(IDX_HDR, 32'h0000000A, RESP_OKAY);
    ms_frame(16'h0001);
    chk({31'h0, parity_error_flag}, 32'h00000001);
    @(posedge clk);
    ce <= 1'b0;
    ms_frame(16'h0000);
    @(posedge clk);
    ce <= 1'b1;
    tick(1);
    chk({31'h0, parity_error_flag}, 32'h00000001);
    wrchk(IDX_MS_CTRL, 32'h00000001, RESP_OKAY);
    wrchk(10'h3FF, 32'h1, RESP_SLVERR);
    rdchk(10'h3FF, 32'h0, RESP_SLVERR);
    @(posedge clk);
    arst_n <= 1'b0;
    repeat (3) @(posedge clk);
    arst_n <= 1'b1;
    tick(2);
    rdchk(IDX_MS_CTRL, 32'h0, RESP_OKAY);
    rdchk(IDX_BUSY_THR, 32'h200, RESP_OKAY);
    rdchk(IDX_FILT_THR, 32'h200, RESP_OKAY);
    rdchk(IDX_HDR, 32'h0, RESP_OKAY);
    rdchk(IDX_MS_STATUS, 32'h0, RESP_OKAY);
    rdchk(IDX_BANK_SEL, 32'h0, RESP_OKAY);
    summarize();
  end
endmodule
